// file: clkout_por_pkg.sv
`default_nettype none
package clkout_por_pkg;

    // system clock rate
    localparam int CLK_FREQ_KHZ      = 20000;
    // least hold of the internal reset after supply recovers
    localparam int POR_HOLD_NS       = 30000;
    localparam int POR_HOLD_CYCLES   =
        (POR_HOLD_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int POR_CNT_W         = 10;
    // oscillator build-up time, counted in resonator edges
    localparam int OSC_BUILDUP_US    = 1000;
    localparam int OSC_FREQ_KHZ      = 8000;
    localparam int OSC_BUILDUP_EDGES =
        OSC_BUILDUP_US * OSC_FREQ_KHZ / 1000;
    localparam int OSC_CNT_W         = 16;
    // reset values
    localparam logic RST_POR_ACTIVE  = 1'b1;
    localparam logic RST_CLK_OUT     = 1'b0;

    // what the clock pin is doing
    typedef enum logic [1:0] {
        OUT_STOPPED,
        OUT_FULL,
        OUT_HALF
    } out_mode_t;

endpackage : clkout_por_pkg
`default_nettype wire

// file: clock_out_and_por_control.sv
`timescale 1ns/1ps
`default_nettype none
module clock_out_and_por_control
    import clkout_por_pkg::*;
#(
    parameter int OSC_EDGES = OSC_BUILDUP_EDGES
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // pins from outside the clock domain
    input  wire logic RESONATOR_INPUT,
    input  wire logic SUPPLY_BELOW_POR,
    // controls from on-chip logic
    input  wire logic CLOCK_PRESCALE_SELECT,
    input  wire logic POWER_DOWN,
    input  wire logic MODULATION_BUSY,
    // outputs
    output var  logic CLOCK_OUT_PIN,
    output var  logic MODULATION_ACTIVE_OUT,
    output var  logic INTERNAL_RESET,
    output var  logic OSC_READY
);

    ////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [1:0] sync_q;
    logic       osc_s;
    logic       supply_low;

    sync_2ff #(.W(2)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   ({RESONATOR_INPUT, SUPPLY_BELOW_POR}),
        .q   (sync_q)
    );

    assign osc_s      = sync_q[1];
    assign supply_low = sync_q[0];

    ////////////////////////////////////////////////////////////////////
    // resonator edge detection

    logic osc_d;
    logic osc_rise;
    logic osc_fall;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            osc_d <= 1'b0;
        end else begin
            osc_d <= osc_s;
        end
    end

    assign osc_rise = osc_s & ~osc_d;
    assign osc_fall = ~osc_s & osc_d;

    ////////////////////////////////////////////////////////////////////
    // power-on reset hold

    logic                 por;
    logic [POR_CNT_W-1:0] por_cnt;
    logic                 next_por;
    logic [POR_CNT_W-1:0] next_por_cnt;

    // reset held while supply is low, then for the hold count
    always_comb begin
        next_por     = por;
        next_por_cnt = por_cnt;
        if (supply_low) begin
            next_por     = 1'b1;
            next_por_cnt = '0;
        end else if (por) begin
            if (por_cnt == POR_CNT_W'(POR_HOLD_CYCLES - 1)) begin
                next_por = 1'b0;
            end else begin
                next_por_cnt = por_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            por     <= RST_POR_ACTIVE;
            por_cnt <= '0;
        end else begin
            por     <= next_por;
            por_cnt <= next_por_cnt;
        end
    end

    assign INTERNAL_RESET = por;

    ////////////////////////////////////////////////////////////////////
    // oscillator build-up watch

    logic                 osc_ready;
    logic [OSC_CNT_W-1:0] osc_cnt;
    logic                 next_osc_ready;
    logic [OSC_CNT_W-1:0] next_osc_cnt;

    // count resonator edges after reset before declaring it stable
    always_comb begin
        next_osc_ready = osc_ready;
        next_osc_cnt   = osc_cnt;
        if (por) begin
            next_osc_ready = 1'b0;
            next_osc_cnt   = '0;
        end else if (!osc_ready && osc_rise) begin
            if (osc_cnt == OSC_CNT_W'(OSC_EDGES - 1)) begin
                next_osc_ready = 1'b1;
            end else begin
                next_osc_cnt = osc_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            osc_ready <= 1'b0;
            osc_cnt   <= '0;
        end else begin
            osc_ready <= next_osc_ready;
            osc_cnt   <= next_osc_cnt;
        end
    end

    assign OSC_READY = osc_ready;

    ////////////////////////////////////////////////////////////////////
    // clock output pin

    out_mode_t mode;
    out_mode_t next_mode;
    out_mode_t want;
    out_mode_t eff;
    logic      clk_out;
    logic      next_clk_out;
    logic      boundary;

    // mode changes only at a resonator rise while the pin is low,
    // where full and half rate both go high: no phase is cut short
    always_comb begin
        next_mode    = mode;
        next_clk_out = clk_out;
        boundary     = osc_rise & ~clk_out;
        if (POWER_DOWN || !osc_ready) begin
            want = OUT_STOPPED;
        end else if (CLOCK_PRESCALE_SELECT) begin
            want = OUT_HALF;
        end else begin
            want = OUT_FULL;
        end
        eff = boundary ? want : mode;
        if (boundary) begin
            next_mode = want;
        end
        unique case (eff)
            OUT_STOPPED: next_clk_out = 1'b0;
            OUT_FULL: begin
                // follow the resonator level
                if (osc_rise) next_clk_out = 1'b1;
                if (osc_fall) next_clk_out = 1'b0;
            end
            OUT_HALF: begin
                // toggle once per resonator period
                if (osc_rise) next_clk_out = ~clk_out;
            end
            default: next_clk_out = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode    <= OUT_STOPPED;
            clk_out <= RST_CLK_OUT;
        end else begin
            mode    <= next_mode;
            clk_out <= next_clk_out;
        end
    end

    assign CLOCK_OUT_PIN = clk_out;

    ////////////////////////////////////////////////////////////////////
    // modulation activity pin

    logic mod_act;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mod_act <= 1'b0;
        end else begin
            mod_act <= MODULATION_BUSY;
        end
    end

    assign MODULATION_ACTIVE_OUT = mod_act;

    ////////////////////////////////////////////////////////////////////
    // checks

    logic [POR_CNT_W-1:0] gap_cnt;

    // cycles since supply was last seen low, saturating
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            gap_cnt <= '0;
        end else if (supply_low) begin
            gap_cnt <= '0;
        end else if (gap_cnt != '1) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    sequence s_boundary_stopped;
        mode == OUT_STOPPED && osc_rise && !clk_out;
    endsequence

    a_stopped_low: assert property (
        @(posedge CLK) disable iff (RST)
        mode == OUT_STOPPED |-> !clk_out)
        else $error("clock pin high while stopped");

    a_full_follow: assert property (
        @(posedge CLK) disable iff (RST)
        mode == OUT_FULL && osc_fall |=> !clk_out)
        else $error("full rate output missed resonator fall");

    a_half_toggle: assert property (
        @(posedge CLK) disable iff (RST)
        mode == OUT_HALF && osc_rise && clk_out |=> !clk_out)
        else $error("half rate output did not toggle");

    // activity pin mirrors the busy input one cycle later, both ways
    a_mod_follow: assert property (
        @(posedge CLK) disable iff (RST)
        mod_act == $past(MODULATION_BUSY))
        else $error("activity pin not following modulation");

    a_por_hold: assert property (
        @(posedge CLK) disable iff (RST)
        $fell(por) |-> gap_cnt >= POR_CNT_W'(POR_HOLD_CYCLES))
        else $error("internal reset released too early");

    a_por_assert: assert property (
        @(posedge CLK) disable iff (RST)
        supply_low |=> por ##1 por)
        else $error("internal reset not raised on low supply");

    a_ready_gate: assert property (
        @(posedge CLK) disable iff (RST)
        s_boundary_stopped ##0 !osc_ready |=> mode == OUT_STOPPED)
        else $error("clock pin started before oscillator stable");

    a_rise_on_edge: assert property (
        @(posedge CLK) disable iff (RST)
        $rose(clk_out) |-> $past(osc_rise))
        else $error("clock pin rose off a resonator rise");

    a_fall_on_edge: assert property (
        @(posedge CLK) disable iff (RST)
        $fell(clk_out) |-> $past(osc_rise) || $past(osc_fall))
        else $error("clock pin fell off a resonator edge");

endmodule : clock_out_and_por_control
`default_nettype wire

// file: mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// partner: microcontroller timer fed by the clock and activity pins
module mcu_model (
    // clock
    input  wire logic        clk,
    // pins from the device
    input  wire logic        clock_in,
    input  wire logic        gate_in,
    input  wire logic        ready_in,
    // what the timer has seen
    output var  logic [15:0] rises,
    output var  logic [15:0] gated,
    output var  logic [7:0]  min_phase
);
    logic       last;
    logic [7:0] phase;
    initial begin
        {last, rises, gated} = '0;
        {phase, min_phase} = 16'hffff;
    end
    // counts clock rises and gated cycles only once settled
    always @(posedge clk) begin
        last <= clock_in;
        phase <= (clock_in != last) ? 8'h01 : phase + 8'(phase != 8'hff);
        if (ready_in && clock_in && !last) rises <= rises + 16'h0001;
        if (ready_in && gate_in) gated <= gated + 16'h0001;
        if (ready_in && clock_in != last && phase < min_phase)
            min_phase <= phase;
    end
endmodule : mcu_model
`default_nettype wire

// file: sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // asynchronous input and its synchronised copy
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] stage;

    // two flops; the first is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end

endmodule : sync_2ff
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 0, rst = 1, res_in = 0, low_sup = 0;
    logic        rate_sel = 0, pd = 0, busy = 0;
    logic        clk_pin, mact, irst, rdy;
    logic [15:0] rises, gated, r0;
    logic [7:0]  minp;
    int          fail_count = 0, samples_checked = 0, cycles = 0, n;

    always #25 clk = ~clk;
    // resonator runs at an eighth of the system clock
    always begin
        repeat (4) @(negedge clk);
        res_in = ~res_in;
    end

    clock_out_and_por_control #(.OSC_EDGES(4)) u_clock_out_and_por_control (
        .CLK(clk), .RST(rst), .RESONATOR_INPUT(res_in),
        .SUPPLY_BELOW_POR(low_sup), .CLOCK_PRESCALE_SELECT(rate_sel),
        .POWER_DOWN(pd), .MODULATION_BUSY(busy), .CLOCK_OUT_PIN(clk_pin),
        .MODULATION_ACTIVE_OUT(mact), .INTERNAL_RESET(irst),
        .OSC_READY(rdy));
    mcu_model u_mcu_model (.clk(clk), .clock_in(clk_pin), .gate_in(mact),
        .ready_in(rdy), .rises(rises), .gated(gated), .min_phase(minp));

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // count cycles until the internal reset lets go, then check ready 60 cycles later
    task automatic t_release(int lo, int hi);
        n = 0;
        while (irst === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("por_hold", 16'(n >= lo && n <= hi), 16'h0001);
        check("clk_gated", clk_pin, 1'b0);
        repeat (60) @(negedge clk);
        check("osc_ready", rdy, 1'b1);
    endtask : t_release

    task automatic t_rate(logic sel, logic [15:0] exp);
        rate_sel = sel;
        repeat (32) @(negedge clk);
        r0 = rises;
        repeat (80) @(negedge clk);
        check("rises", rises - r0, exp);
    endtask : t_rate

    task automatic t_pd();
        pd = 1;
        repeat (32) @(negedge clk);
        r0 = rises;
        repeat (80) @(negedge clk);
        check("pd_rises", rises - r0, 16'h0000);
        check("pd_pin", clk_pin, 1'b0);
        pd = 0;
        t_rate(1'b0, 16'h000a);
    endtask : t_pd

    task automatic t_mod();
        r0 = gated;
        busy = 1;
        @(negedge clk);
        check("mod_on", mact, 1'b1);
        busy = 0;
        @(negedge clk);
        check("mod_off", mact, 1'b0);
        check("mod_cycles", gated - r0, 16'h0001);
    endtask : t_mod

    task automatic t_supply();
        low_sup = 1;
        repeat (4) @(negedge clk);
        check("por_on", irst, 1'b1);
        repeat (20) @(negedge clk);
        check("por_ready", rdy, 1'b0);
        low_sup = 0;
        t_release(600, 606);
        t_rate(1'b0, 16'h000a);
    endtask : t_supply

    // cycle ceiling against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        check("rst_por", irst, 1'b1);
        check("rst_ready", rdy, 1'b0);
        rst = 0;
        t_release(600, 604);
        t_rate(1'b0, 16'h000a);
        t_rate(1'b1, 16'h0005);
        t_rate(1'b0, 16'h000a);
        t_pd();
        t_mod();
        check("min_phase", 16'(minp >= 8'h04), 16'h0001);
        t_supply();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
